// File: inc/sr_pkg.sv
// Shared constants for the serial receiver and its transmitting station
package sr_pkg;
  // ==========================================================
  // Bit timing
  localparam int BASIC_DIV = 27;        // Clock cycles per basic clock pulse
  localparam int DIV_W = 5;
  localparam int TICKS_PER_BIT = 16;    // Basic pulses per bit
  localparam int MID_TICK = 8;          // Pulse on which a bit is latched
  localparam int BIT_CYCLES = BASIC_DIV * TICKS_PER_BIT;
  localparam int BITCNT_W = 9;
  localparam int FRAME_MAX = 12;

  // ==========================================================
  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h8;

  // ==========================================================
  // Control register fields
  localparam int CTL_RX_ENABLE = 0;
  localparam int CTL_RX_IRQ_ENABLE = 1;
  localparam int CTL_ID_WAIT = 2;
  localparam int CTL_SEVEN_BIT = 3;
  localparam int CTL_PARITY_ENABLE = 4;
  localparam int CTL_ODD_PARITY = 5;
  localparam int CTL_MULTIPROC = 6;
  localparam int CTL_TWO_STOP = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========================================================
  // Status register fields
  localparam int ST_FULL = 0;
  localparam int ST_OVERRUN = 1;
  localparam int ST_FRAMING = 2;
  localparam int ST_PARITY = 3;
  localparam int ST_MP_BIT = 4;
  localparam logic ST_FLAG_RESET = 1'b0;

  // ==========================================================
  // State machines
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_EXTRA = 5'b01000,
    RX_STOP = 5'b10000
  } sr_rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } sr_tx_state_t;
endpackage : sr_pkg

// File: inc/sr_link_if.sv
// Serial line between the transmitting station and the receiver
`timescale 1ns/100ps
`default_nettype none
interface sr_link_if;
  logic line; // Idle high, start bit low

  modport tx (output line);
  modport rx (input line);
endinterface : sr_link_if
`default_nettype wire

// File: hw/sr_transmitter.sv
// Transmitting station: sends one framed character per request
`timescale 1ns/100ps
`default_nettype none
module sr_transmitter (
  // System
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Character request
  input wire logic [7:0] txData,
  input wire logic txMpBit,
  input wire logic txStart,
  // Frame format
  input wire logic sevenBit,
  input wire logic parityEnable,
  input wire logic oddParity,
  input wire logic multiprocFormat,
  input wire logic twoStop,
  // Status
  output logic txBusy,
  output logic txDone,
  // Serial line
  sr_link_if.tx link
);
  // ========================================================
  // Frame assembly
  // Start, data LSB first, parity or multiprocessor bit, stop bits
  function automatic logic [11:0] buildFrame(input logic [7:0] d,
                                             input logic seven,
                                             input logic extra,
                                             input logic extraVal);
    logic [11:0] f;
    f = 12'hfff;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < 7 || !seven) begin
        f[1 + i] = d[i];
      end
    end
    if (extra) begin
      f[seven ? 8 : 9] = extraVal;
    end
    return f;
  endfunction : buildFrame

  sr_pkg::sr_tx_state_t state_r;
  logic [11:0] shift_r;
  logic [3:0] bitsLeft_r;
  logic [sr_pkg::BITCNT_W-1:0] cyc_r;
  logic line_r;
  logic busy_r;
  logic done_r;

  wire logic mpSel = multiprocFormat;
  wire logic extraOn = mpSel | parityEnable;
  wire logic parBit = (^txData[6:0]) ^ (sevenBit ? 1'b0 : txData[7])
                      ^ oddParity;
  wire logic extraVal = mpSel ? txMpBit : parBit;
  // Start, data, optional extra bit and stop bits: 9 to 12 bits
  wire logic [3:0] frameLen = 4'ha - {3'h0, sevenBit} + {3'h0, extraOn}
                              + {3'h0, twoStop};
  wire logic [11:0] frame = buildFrame(txData, sevenBit, extraOn, extraVal);
  wire logic bitEnd = (cyc_r == sr_pkg::BITCNT_W'(sr_pkg::BIT_CYCLES - 1));

  // Sequencer and line driver
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= sr_pkg::TX_IDLE;
      shift_r <= 12'hfff;
      bitsLeft_r <= 4'h0;
      cyc_r <= '0;
      line_r <= 1'b1;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (ce) begin
      done_r <= 1'b0;
      case (state_r)
        sr_pkg::TX_IDLE: begin
          if (txStart) begin
            shift_r <= {1'b1, frame[11:1]};
            line_r <= frame[0];
            bitsLeft_r <= frameLen - 4'h1;
            cyc_r <= '0;
            busy_r <= 1'b1;
            state_r <= sr_pkg::TX_SEND;
          end
        end
        sr_pkg::TX_SEND: begin
          cyc_r <= bitEnd ? '0 : cyc_r + 1'b1;
          if (bitEnd) begin
            if (bitsLeft_r == 4'h0) begin
              line_r <= 1'b1;
              busy_r <= 1'b0;
              done_r <= 1'b1;
              state_r <= sr_pkg::TX_IDLE;
            end else begin
              line_r <= shift_r[0];
              shift_r <= {1'b1, shift_r[11:1]};
              bitsLeft_r <= bitsLeft_r - 4'h1;
            end
          end
        end
        default: state_r <= sr_pkg::TX_IDLE;
      endcase
    end
  end

  assign link.line = line_r;
  assign txBusy = busy_r;
  assign txDone = done_r;
endmodule : sr_transmitter
`default_nettype wire

// File: hw/sr_receiver.sv
// Asynchronous serial receiver with multiprocessor ID filtering
//
// Overview of operation
// - Start edge syncs, shifts character, checks parity/stop
// - Overrun when full: set flag, keep data
// - Parity mismatch sets flag, data still stored
// - Stop bit zero sets framing flag, data stored
// - Any error flag with enable raises error request
// - Clean character stored, full set, full request
// - Errored character leaves full flag unchanged
// - Any error flag set blocks further reception
// - Software clears error and full flags to resume
// - Overrun plus other errors: all flags, discard
// - Framing plus parity: both flags, data stored
// - Multiprocessor bit one is ID, zero data
// - ID wait blocks transfer, errors and flags
// - ID character sets mp flag, ends wait
// - Multiprocessor format ignores parity enable setting
// - Transmitter sends its mp bit per character
// - Station compares ID, skips data on mismatch
// - Sixteen basic pulses per bit, start-edge aligned
// - Bits latched on eighth pulse, mid-bit
// - Receive disable keeps flags and data register
// - Length, parity, mp, stop count select format
`timescale 1ns/100ps
`default_nettype none
module sr_receiver (
  // System
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Interrupt requests
  output logic receiveErrorIrq,
  output logic receiveFullIrq,
  // Serial line
  sr_link_if.rx link
);
  // ========================================================
  // Line synchroniser, three stages with agreement filter
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic lineFilt_r;
  logic linePrev_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      sync3_r <= 1'b1;
      lineFilt_r <= 1'b1;
      linePrev_r <= 1'b1;
    end else if (ce) begin
      sync1_r <= link.line;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        lineFilt_r <= sync3_r;
      end
      linePrev_r <= lineFilt_r;
    end
  end

  // ========================================================
  // Registers
  logic [7:0] ctrl_r;
  logic full_r;
  logic ovr_r;
  logic frmFlag_r;
  logic parFlag_r;
  logic mpFlag_r;
  logic [7:0] data_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic errIrq_r;
  logic fullIrq_r;

  wire logic rxEnable = ctrl_r[sr_pkg::CTL_RX_ENABLE];
  wire logic irqEnable = ctrl_r[sr_pkg::CTL_RX_IRQ_ENABLE];
  wire logic idWait = ctrl_r[sr_pkg::CTL_ID_WAIT];
  wire logic sevenSel = ctrl_r[sr_pkg::CTL_SEVEN_BIT];
  wire logic mpFmt = ctrl_r[sr_pkg::CTL_MULTIPROC];
  wire logic parOn = ctrl_r[sr_pkg::CTL_PARITY_ENABLE] & ~mpFmt;
  wire logic anyErr = ovr_r | frmFlag_r | parFlag_r;
  wire logic rxGo = rxEnable & ~anyErr;

  // ========================================================
  // Basic clock and bit sampling
  sr_pkg::sr_rx_state_t state_r;
  logic [sr_pkg::DIV_W-1:0] basicCnt_r;
  logic [3:0] subCnt_r;
  logic [2:0] bitIdx_r;
  logic [7:0] shift_r;
  logic extra_r;

  wire logic startFall = linePrev_r & ~lineFilt_r;
  wire logic basicTick = (basicCnt_r == sr_pkg::DIV_W'(sr_pkg::BASIC_DIV - 1));
  wire logic [3:0] sampleAt = (state_r == sr_pkg::RX_START)
                              ? 4'(sr_pkg::MID_TICK - 1)
                              : 4'(sr_pkg::TICKS_PER_BIT - 1);
  wire logic sampleNow = basicTick & (subCnt_r == sampleAt);
  wire logic [2:0] lastIdx = sevenSel ? 3'h6 : 3'h7;

  // ========================================================
  // Character completion decode
  wire logic [7:0] rxChar = sevenSel ? {1'b0, shift_r[7:1]} : shift_r;
  wire logic done = sampleNow & (state_r == sr_pkg::RX_STOP);
  wire logic isId = mpFmt & extra_r;
  wire logic accept = done & (~idWait | isId);
  wire logic frErr = ~lineFilt_r;
  wire logic parErr = parOn & ((^rxChar ^ extra_r)
                               != ctrl_r[sr_pkg::CTL_ODD_PARITY]);
  wire logic setOvr = accept & full_r;
  wire logic setFrm = accept & frErr;
  wire logic setPar = accept & parErr;
  wire logic loadData = accept & ~full_r;
  wire logic setFull = loadData & ~frErr & ~parErr;
  wire logic idEnd = done & idWait & isId;

  // ========================================================
  // Bus decode
  wire logic busReq = read | write;
  wire logic wrTake = write & ~wait_r;
  wire logic ctrlWr = wrTake & (address == sr_pkg::OFS_CTRL);
  wire logic statWr = wrTake & (address == sr_pkg::OFS_STATUS);
  wire logic [31:0] statWord = {27'h0, mpFlag_r, parFlag_r, frmFlag_r,
                                ovr_r, full_r};
  wire logic [31:0] rdMux = (address == sr_pkg::OFS_CTRL) ? {24'h0, ctrl_r} :
                            (address == sr_pkg::OFS_STATUS) ? statWord :
                            (address == sr_pkg::OFS_DATA) ? {24'h0, data_r} :
                            32'h0;

  // Flag next values: a set in the clearing cycle wins
  wire logic full_nxt = setFull
                        | (full_r & ~(statWr & ~writedata[sr_pkg::ST_FULL]));
  wire logic ovr_nxt = setOvr
                       | (ovr_r & ~(statWr & ~writedata[sr_pkg::ST_OVERRUN]));
  wire logic clrFrm = statWr & ~writedata[sr_pkg::ST_FRAMING];
  wire logic clrPar = statWr & ~writedata[sr_pkg::ST_PARITY];
  wire logic frmFlag_nxt = setFrm | (frmFlag_r & ~clrFrm);
  wire logic parFlag_nxt = setPar | (parFlag_r & ~clrPar);

  // Receive sequencer; disabling aborts the frame only
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= sr_pkg::RX_IDLE;
      basicCnt_r <= '0;
      subCnt_r <= 4'h0;
      bitIdx_r <= 3'h0;
      shift_r <= 8'h00;
      extra_r <= 1'b0;
    end else if (ce) begin
      basicCnt_r <= basicTick ? '0 : basicCnt_r + 1'b1;
      if (basicTick) begin
        subCnt_r <= sampleNow ? 4'h0 : subCnt_r + 4'h1;
      end
      case (state_r)
        sr_pkg::RX_IDLE: begin
          if (rxGo && startFall) begin
            basicCnt_r <= '0;
            subCnt_r <= 4'h0;
            state_r <= sr_pkg::RX_START;
          end
        end
        sr_pkg::RX_START: begin
          if (sampleNow) begin
            bitIdx_r <= 3'h0;
            state_r <= lineFilt_r ? sr_pkg::RX_IDLE : sr_pkg::RX_DATA;
          end
        end
        sr_pkg::RX_DATA: begin
          if (sampleNow) begin
            shift_r <= {lineFilt_r, shift_r[7:1]};
            bitIdx_r <= bitIdx_r + 3'h1;
            if (bitIdx_r == lastIdx) begin
              extra_r <= 1'b0;
              state_r <= (mpFmt | parOn) ? sr_pkg::RX_EXTRA : sr_pkg::RX_STOP;
            end
          end
        end
        sr_pkg::RX_EXTRA: begin
          if (sampleNow) begin
            extra_r <= lineFilt_r;
            state_r <= sr_pkg::RX_STOP;
          end
        end
        sr_pkg::RX_STOP: begin
          if (sampleNow) begin
            state_r <= sr_pkg::RX_IDLE;
          end
        end
        default: state_r <= sr_pkg::RX_IDLE;
      endcase
      if (!rxEnable) begin
        state_r <= sr_pkg::RX_IDLE;
      end
    end
  end

  // Status flags and data register
  always_ff @(posedge clk) begin
    if (rst) begin
      full_r <= sr_pkg::ST_FLAG_RESET;
      ovr_r <= sr_pkg::ST_FLAG_RESET;
      frmFlag_r <= sr_pkg::ST_FLAG_RESET;
      parFlag_r <= sr_pkg::ST_FLAG_RESET;
      mpFlag_r <= sr_pkg::ST_FLAG_RESET;
      data_r <= 8'h00;
    end else if (ce) begin
      full_r <= full_nxt;
      ovr_r <= ovr_nxt;
      frmFlag_r <= frmFlag_nxt;
      parFlag_r <= parFlag_nxt;
      if (accept && mpFmt) begin
        mpFlag_r <= extra_r;
      end
      if (loadData) begin
        data_r <= rxChar;
      end
    end
  end

  // Control register; hardware ends the ID wait
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= sr_pkg::CTRL_RESET;
    end else if (ce) begin
      if (ctrlWr) begin
        ctrl_r <= writedata[7:0];
      end else if (idEnd) begin
        ctrl_r[sr_pkg::CTL_ID_WAIT] <= 1'b0;
      end
    end
  end

  // Bus handshake: one wait cycle, then the access completes
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
    end else if (ce) begin
      wait_r <= ~(busReq & wait_r);
      if (read && wait_r) begin
        rdata_r <= rdMux;
      end
    end
  end

  // Interrupt requests as levels
  always_ff @(posedge clk) begin
    if (rst) begin
      errIrq_r <= 1'b0;
      fullIrq_r <= 1'b0;
    end else if (ce) begin
      errIrq_r <= irqEnable & anyErr;
      fullIrq_r <= irqEnable & full_r;
    end
  end

  assign readdata = rdata_r;
  assign waitrequest = wait_r;
  assign receiveErrorIrq = errIrq_r;
  assign receiveFullIrq = fullIrq_r;
endmodule : sr_receiver
`default_nettype wire

// File: bench/sr_assertions.sv
// Concurrent checks on the serial line, bus handshake and requests
`timescale 1ns/100ps
`default_nettype none
module sr_assertions (
  // System
  input wire logic clk,
  input wire logic rst,
  // Serial line and transmitter status
  input wire logic line,
  input wire logic txBusy,
  input wire logic txDone,
  // Register bus and requests
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  input wire logic receiveErrorIrq,
  input wire logic receiveFullIrq
);
  logic [12:0] busyCnt_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // Helpers
  // Counts cycles of one frame on the line
  always_ff @(posedge clk) begin
    if (rst || !txBusy)
      busyCnt_r <= 13'h0000;
    else
      busyCnt_r <= busyCnt_r + 13'h0001;
  end

  // Request waiting for its answer
  sequence bus_req_s;
    (read || write) && waitrequest;
  endsequence

  // ==========================================================
  // Line framing
  idle_line_a: assert property (!txBusy |-> line)
    else $error("line not high outside a frame");
  start_low_a: assert property ($rose(txBusy) |-> !line)
    else $error("frame does not open with a low start bit");
  bit_hold_a: assert property ($changed(line) |=> $stable(line)[*8])
    else $error("line bit shorter than expected");
  // Nine to twelve bits of 432 cycles each
  frame_len_a: assert property (txDone |->
    busyCnt_r >= 13'h0f30 && busyCnt_r <= 13'h1440)
    else $error("frame length outside legal formats");
  done_pulse_a: assert property (txDone |-> !txBusy ##1 !txDone)
    else $error("transmit done not a single pulse");

  // ==========================================================
  // Register bus and requests
  wait_one_a: assert property (bus_req_s |=> !waitrequest)
    else $error("bus answer not after one wait state");
  wait_short_a: assert property (!waitrequest |=> waitrequest)
    else $error("bus answer held too long");
  rdata_hold_a: assert property (!(read && waitrequest) |=>
    $stable(readdata))
    else $error("read data changed without a read");
  err_clear_a: assert property ($fell(receiveErrorIrq) |->
    $past(write) || $past(write, 2))
    else $error("error request dropped without software write");
  full_clear_a: assert property ($fell(receiveFullIrq) |->
    $past(write) || $past(write, 2))
    else $error("full request dropped without software write");
endmodule : sr_assertions
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench: transmitter feeds receiver over the serial link
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errTotal++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  // Step: ctrl, tx format, char, mp bit, clear first, status, data
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] fmt;
    logic [7:0] ch;
    logic mp;
    logic clr;
    logic [7:0] st;
    logic [7:0] dat;
  } sr_step_t;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic receiveErrorIrq;
  logic receiveFullIrq;
  logic [7:0] txData = 8'h00;
  logic txMpBit = 1'b0;
  logic txStart = 1'b0;
  logic [7:0] txFmt = 8'h00;
  logic txBusy;
  logic txDone;
  logic [31:0] rd;
  int errTotal = 0;
  int checks = 0;
  int cycles = 0;
  sr_step_t steps[14] = '{
    '{8'h03, 8'h00, 8'ha5, 1'b0, 1'b1, 8'h01, 8'ha5},
    '{8'h03, 8'h00, 8'h3c, 1'b0, 1'b0, 8'h03, 8'ha5},
    '{8'h03, 8'h00, 8'h11, 1'b0, 1'b0, 8'h03, 8'ha5},
    '{8'h13, 8'h30, 8'h5a, 1'b0, 1'b1, 8'h08, 8'h5a},
    '{8'h0b, 8'h00, 8'h00, 1'b0, 1'b1, 8'h04, 8'h00},
    '{8'h1b, 8'h30, 8'h40, 1'b0, 1'b1, 8'h0c, 8'h40},
    '{8'h33, 8'h30, 8'hc3, 1'b0, 1'b1, 8'h01, 8'hc3},
    '{8'h0b, 8'h00, 8'h00, 1'b0, 1'b0, 8'h07, 8'hc3},
    '{8'h93, 8'h90, 8'h96, 1'b0, 1'b1, 8'h01, 8'h96},
    '{8'h53, 8'h40, 8'h23, 1'b0, 1'b1, 8'h01, 8'h23},
    '{8'h57, 8'h40, 8'h44, 1'b0, 1'b1, 8'h00, 8'h23},
    '{8'h57, 8'h40, 8'h5b, 1'b1, 1'b1, 8'h11, 8'h5b},
    // ID 5b is not this station's: software re-arms the wait
    '{8'h57, 8'h40, 8'h31, 1'b0, 1'b1, 8'h10, 8'h5b},
    '{8'h57, 8'h40, 8'h7e, 1'b1, 1'b0, 8'h11, 8'h7e}
  };

  // ==========================================================
  // Design, link and checker
  sr_link_if sr_link_if_i ();
  sr_transmitter sr_transmitter_i (.clk, .rst, .ce(1'b1), .txData,
    .txMpBit, .txStart, .sevenBit(txFmt[3]), .parityEnable(txFmt[4]),
    .oddParity(txFmt[5]), .multiprocFormat(txFmt[6]), .twoStop(txFmt[7]),
    .txBusy, .txDone, .link(sr_link_if_i.tx));
  sr_receiver sr_receiver_i (.clk, .rst, .ce(1'b1), .address, .read,
    .write, .writedata, .readdata, .waitrequest, .receiveErrorIrq,
    .receiveFullIrq, .link(sr_link_if_i.rx));
  sr_assertions sr_assertions_i (.clk, .rst, .line(sr_link_if_i.line),
    .txBusy, .txDone, .read, .write, .waitrequest, .readdata,
    .receiveErrorIrq, .receiveFullIrq);

  // Clock and hang limit
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      errTotal++;
      finish_test();
    end
  end

  // ==========================================================
  // Tasks
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // One Avalon access, held until waitrequest is seen low
  task automatic bus_xfer(input logic wr, input logic [3:0] a,
      input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus_xfer

  task automatic chk_rd(input logic [3:0] a, input logic [31:0] e);
    bus_xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : chk_rd

  // Sends one character and waits for the frame to end
  task automatic send(input logic [7:0] c, input logic mp);
    @(posedge clk);
    txData <= c;
    txMpBit <= mp;
    txStart <= 1'b1;
    @(posedge clk);
    txStart <= 1'b0;
    do @(posedge clk); while (txDone !== 1'b1);
    repeat (3) @(posedge clk);
  endtask : send

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk_rd(sr_pkg::OFS_STATUS, 32'h0);
    bus_xfer(1'b1, 4'hc, 32'hff);
    chk_rd(4'hc, 32'h0);
    chk_rd(sr_pkg::OFS_CTRL, 32'h0);
    foreach (steps[i]) begin
      if (steps[i].clr)
        bus_xfer(1'b1, sr_pkg::OFS_STATUS, 32'h0);
      bus_xfer(1'b1, sr_pkg::OFS_CTRL, {24'h0, steps[i].ctl});
      txFmt <= steps[i].fmt;
      send(steps[i].ch, steps[i].mp);
      chk_rd(sr_pkg::OFS_STATUS, {24'h0, steps[i].st});
      chk_rd(sr_pkg::OFS_DATA, {24'h0, steps[i].dat});
      `CHK(receiveFullIrq, steps[i].st[0])
      `CHK(receiveErrorIrq, |steps[i].st[3:1])
    end
    chk_rd(sr_pkg::OFS_CTRL, 32'h53);
    bus_xfer(1'b1, sr_pkg::OFS_CTRL, 32'h0);
    chk_rd(sr_pkg::OFS_STATUS, 32'h11);
    chk_rd(sr_pkg::OFS_DATA, 32'h7e);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
